/* shared/fault_supervisor_regs.svh */
// Purpose: Offsets, fields, reset values and counts of the fault supervisor
// Assumes: Byte addresses on a 32-bit AHB-Lite bus
// Notes: Counts are in phase-clock ticks unless named otherwise
`ifndef FAULT_SUPERVISOR_REGS_SVH
`define FAULT_SUPERVISOR_REGS_SVH

`define CTRL_ADDR 8'h00
`define STATUS_ADDR 8'h04
`define CTRL_RESET 32'h0000_0000
`define CTRL_MODE_LSB 0
`define CTRL_VID_LSB 2
`define CTRL_TARGET_LSB 8
`define SS_DELAY_TICKS 13'h0010
`define SS_STEP_TICKS 13'h0010
`define OC_WAIT_TICKS 13'h1000
`define NOLOAD_DELAY_TICKS 2'h2
`define NOLOAD_CODE_6 5'h1F
`define NOLOAD_CODE_5 5'h1F

`endif

/* shared/fault_supervisor_pkg.sv */
// Purpose: Types shared by the fault supervisor
// Assumes: Nothing beyond the register header
// Notes: States are one-hot
package fault_supervisor_pkg;

	typedef enum logic [1:0] {
		MODE_SIX_BIT = 2'h0,
		MODE_FIVE_A = 2'h1,
		MODE_FIVE_B = 2'h2
	} mode_t;

	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_SS_DELAY = 5'h02,
		ST_SS_RAMP = 5'h04,
		ST_RUN = 5'h08,
		ST_OC_WAIT = 5'h10
	} state_t;

	// Comparator and enable pins, all asynchronous to hclk
	typedef struct packed {
		logic threshold_enable_in;
		logic por_ok;
		logic phase_tick;
		logic uv_below_82;
		logic uv_above_85;
		logic ov_ref_trip;
		logic ov_ref_clear;
		logic ov_fixed_trip;
		logic ov_fixed_clear;
		logic open_sense;
		logic overcurrent;
	} pins_t;

	typedef struct packed {
		pins_t sync1;
		pins_t sync2;
		logic tick_d;
		state_t state;
		logic [12:0] cnt;
		logic [7:0] ref_code;
		logic [1:0] noload_cnt;
		logic ov;
		logic ov_cause_fixed;
		logic ov_ref_early;
		logic uv;
		logic [31:0] ctrl;
		logic wr_pend;
		logic [7:0] waddr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic pg_release;
		logic [2:0] low_force;
		logic [2:0] low_en;
		logic [2:0] high_en;
		logic fixed_en;
		logic fixed_high;
		logic ov_shutdown_level;
	} regs_t;

endpackage : fault_supervisor_pkg

/* rtl/fault_supervisor_power_good.sv */
// Purpose: Fault supervision, hiccup control and power-good for a buck controller
// Assumes: Comparator results arrive as logic levels from analog circuits
// Notes: Gate outputs are permits; the PWM logic elsewhere does the switching
`include "fault_supervisor_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module fault_supervisor_power_good #(
	parameter logic [12:0] OC_WAIT_TICKS = `OC_WAIT_TICKS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic threshold_enable_in,
	input wire logic por_ok,
	input wire logic phase_tick,
	input wire logic uv_below_82,
	input wire logic uv_above_85,
	input wire logic ov_ref_trip,
	input wire logic ov_ref_clear,
	input wire logic ov_fixed_trip,
	input wire logic ov_fixed_clear,
	input wire logic open_sense,
	input wire logic overcurrent,
	output logic power_good_out_o,
	output logic power_good_out_oe_n,
	output logic [2:0] low_side_drive_force,
	output logic [2:0] low_side_drive_enable,
	output logic [2:0] high_side_drive_enable,
	output logic [7:0] ref_code,
	output logic fixed_overvoltage_limit_enable,
	output logic fixed_overvoltage_limit_high,
	output logic overvoltage_shutdown_level
);

	fault_supervisor_pkg::regs_t s;
	fault_supervisor_pkg::regs_t next_s;
	fault_supervisor_pkg::pins_t pins;
	fault_supervisor_pkg::mode_t mode;
	logic tick;
	logic noload_code;
	logic noload;
	logic enabled;
	logic soft_start;
	logic [5:0] vid;
	logic [7:0] target;
	logic [12:0] wait_last;
	logic [31:0] status_word;

	assign pins = '{threshold_enable_in, por_ok, phase_tick, uv_below_82,
		uv_above_85, ov_ref_trip, ov_ref_clear, ov_fixed_trip,
		ov_fixed_clear, open_sense, overcurrent};

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_s = s;
		// Pins are read only after the second stage
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;
		// One count per rising edge, however long the tick stays high
		next_s.tick_d = s.sync2.phase_tick;
		tick = s.sync2.phase_tick & ~s.tick_d;

		mode = fault_supervisor_pkg::mode_t'(s.ctrl[`CTRL_MODE_LSB +: 2]);
		vid = s.ctrl[`CTRL_VID_LSB +: 6];
		target = s.ctrl[`CTRL_TARGET_LSB +: 8];
		// Counter starts at zero, so the wait closes on its last tick
		wait_last = OC_WAIT_TICKS - 13'h0001;

		// Six-bit table: top five bits all ones covers both no-load codes
		if (mode == fault_supervisor_pkg::MODE_SIX_BIT) begin
			noload_code = (vid[5:1] == `NOLOAD_CODE_6);
		end else begin
			noload_code = (vid[4:0] == `NOLOAD_CODE_5);
		end
		// Counter stops at its limit so the shutdown holds while the code stays
		if (!noload_code) begin
			next_s.noload_cnt = 2'h0;
		end else if (tick && s.noload_cnt != `NOLOAD_DELAY_TICKS) begin
			next_s.noload_cnt = s.noload_cnt + 2'h1;
		end
		noload = (s.noload_cnt == `NOLOAD_DELAY_TICKS);
		enabled = s.sync2.threshold_enable_in & s.sync2.por_ok & ~noload;

		// ---------------------------------------------------------------
		// Bus slave, zero wait states
		// ---------------------------------------------------------------
		// Status word, most significant field first
		status_word = {
			13'h0000,
			s.ref_code,
			s.noload_cnt,
			s.uv,
			s.ov_cause_fixed,
			s.ov,
			s.pg_release,
			s.state
		};
		next_s.hreadyout = 1'b1;
		// Write data follows its address by a cycle, so the address is kept
		if (s.wr_pend && s.waddr == `CTRL_ADDR) begin
			next_s.ctrl = hwdata;
		end
		next_s.wr_pend = 1'b0;
		if (hsel && hready && htrans[1]) begin
			next_s.wr_pend = hwrite;
			next_s.waddr = haddr[7:0];
			case (haddr[7:0])
				`CTRL_ADDR: begin
					next_s.hrdata = s.ctrl;
				end
				`STATUS_ADDR: begin
					next_s.hrdata = status_word;
				end
				default: begin
					next_s.hrdata = 32'h0000_0000;
				end
			endcase
		end

		// ---------------------------------------------------------------
		// Soft-start, run and hiccup sequence
		// ---------------------------------------------------------------
		soft_start = (s.state == fault_supervisor_pkg::ST_SS_DELAY) ||
			(s.state == fault_supervisor_pkg::ST_SS_RAMP);
		if (!enabled || s.sync2.open_sense) begin
			next_s.state = fault_supervisor_pkg::ST_OFF;
			next_s.cnt = 13'h0000;
			next_s.ref_code = 8'h00;
		end else begin
			case (s.state)
				fault_supervisor_pkg::ST_OFF: begin
					// Open sense cleared lands here, so restart is a full soft-start
					next_s.state = fault_supervisor_pkg::ST_SS_DELAY;
					next_s.cnt = 13'h0000;
				end
				fault_supervisor_pkg::ST_SS_DELAY: begin
					if (tick) begin
						next_s.cnt = s.cnt + 13'h0001;
						if (s.cnt == `SS_DELAY_TICKS - 13'h0001) begin
							next_s.state = fault_supervisor_pkg::ST_SS_RAMP;
							next_s.cnt = 13'h0000;
						end
					end
				end
				fault_supervisor_pkg::ST_SS_RAMP: begin
					// A target already reached skips the ramp
					if (s.ref_code >= target) begin
						next_s.state = fault_supervisor_pkg::ST_RUN;
					end else if (tick) begin
						next_s.cnt = s.cnt + 13'h0001;
						if (s.cnt == `SS_STEP_TICKS - 13'h0001) begin
							next_s.cnt = 13'h0000;
							next_s.ref_code = s.ref_code + 8'h01;
						end
					end
				end
				fault_supervisor_pkg::ST_RUN: begin
					// Target changes after start track one step at once
					next_s.ref_code = target;
				end
				fault_supervisor_pkg::ST_OC_WAIT: begin
					if (tick) begin
						next_s.cnt = s.cnt + 13'h0001;
						if (s.cnt == wait_last) begin
							next_s.state = fault_supervisor_pkg::ST_SS_DELAY;
							next_s.cnt = 13'h0000;
						end
					end
				end
				default: begin
					next_s.state = fault_supervisor_pkg::ST_OFF;
				end
			endcase
			// From OFF nothing is switching, so overcurrent waits for the start
			if (s.sync2.overcurrent && s.state != fault_supervisor_pkg::ST_OC_WAIT &&
				s.state != fault_supervisor_pkg::ST_OFF) begin
				next_s.state = fault_supervisor_pkg::ST_OC_WAIT;
				next_s.cnt = 13'h0000;
				next_s.ref_code = 8'h00;
			end
		end

		// ---------------------------------------------------------------
		// Overvoltage and undervoltage monitors
		// ---------------------------------------------------------------
		// No-load codes never touch this, so they cannot clear a trip
		// Below power-on reset the clamp is resistive and outside this logic
		// Ref above while fixed is not means the fixed level is the higher one
		next_s.ov_ref_early = s.sync2.ov_ref_trip & ~s.sync2.ov_fixed_trip;
		if (!s.sync2.por_ok) begin
			next_s.ov = 1'b0;
		end else if (!s.ov) begin
			if (soft_start) begin
				// Trip level is the higher of the two, so both must be exceeded
				if (s.sync2.ov_ref_trip && s.sync2.ov_fixed_trip) begin
					next_s.ov = 1'b1;
					// Last comparator to cross names the level that tripped
					next_s.ov_cause_fixed = s.ov_ref_early;
				end
			end else if (s.sync2.ov_ref_trip) begin
				next_s.ov = 1'b1;
				next_s.ov_cause_fixed = 1'b0;
			end
		end else if (s.ov_cause_fixed ? s.sync2.ov_fixed_clear : s.sync2.ov_ref_clear) begin
			next_s.ov = 1'b0;
		end
		// Band between the two thresholds keeps the last verdict
		if (s.sync2.uv_below_82) begin
			next_s.uv = 1'b1;
		end else if (s.sync2.uv_above_85) begin
			next_s.uv = 1'b0;
		end

		// ---------------------------------------------------------------
		// Outputs
		// ---------------------------------------------------------------
		// Overvoltage clamp wins even during the hiccup wait
		next_s.low_force = s.ov ? 3'h7 : 3'h0;
		if (!s.ov && (s.state == fault_supervisor_pkg::ST_SS_RAMP ||
			s.state == fault_supervisor_pkg::ST_RUN)) begin
			next_s.low_en = 3'h7;
			next_s.high_en = 3'h7;
		end else begin
			next_s.low_en = 3'h0;
			next_s.high_en = 3'h0;
		end
		// Overcurrent drops power-good in the same cycle as the wait state is entered
		next_s.pg_release = (s.state == fault_supervisor_pkg::ST_RUN) && enabled &&
			!s.ov && !s.uv && !s.sync2.overcurrent;
		next_s.fixed_en = soft_start;
		// Only the five-bit mode A table uses the higher limit
		next_s.fixed_high = (mode == fault_supervisor_pkg::MODE_FIVE_A);
		next_s.ov_shutdown_level = noload;
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.state <= fault_supervisor_pkg::ST_OFF;
			s.ctrl <= `CTRL_RESET;
			s.hreadyout <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ---------------------------------------------------------------
	// Port drivers
	// ---------------------------------------------------------------
	assign hrdata = s.hrdata;
	assign hreadyout = s.hreadyout;
	// Single slave with no error cases
	assign hresp = s.wr_pend & 1'b0;
	// Open drain: the pin is only ever pulled low, never driven high
	assign power_good_out_o = 1'b0;
	assign power_good_out_oe_n = s.pg_release;
	assign low_side_drive_force = s.low_force;
	assign low_side_drive_enable = s.low_en;
	assign high_side_drive_enable = s.high_en;
	assign ref_code = s.ref_code;
	assign fixed_overvoltage_limit_enable = s.fixed_en;
	assign fixed_overvoltage_limit_high = s.fixed_high;
	assign overvoltage_shutdown_level = s.ov_shutdown_level;

endmodule : fault_supervisor_power_good

`default_nettype wire

/* dv/fault_supervisor_checker.sv */
// Purpose: Port assertions for the fault supervisor
// Assumes: Fault pins are held for several hclk cycles
// Notes: Repeat counts cover the two-stage synchroniser
`timescale 1ns/10ps
`default_nettype none
module fault_supervisor_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic threshold_enable_in,
	input wire logic por_ok,
	input wire logic uv_below_82,
	input wire logic ov_ref_trip,
	input wire logic ov_fixed_trip,
	input wire logic open_sense,
	input wire logic overcurrent,
	input wire logic power_good_out_oe_n,
	input wire logic [2:0] low_side_drive_force,
	input wire logic [2:0] high_side_drive_enable,
	input wire logic fixed_overvoltage_limit_enable
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	a_disable_pg_low: assert property ((!threshold_enable_in || !por_ok) [*6] |-> !power_good_out_oe_n)
		else $error("power good released while disabled");
	a_uv_pg_low: assert property (uv_below_82 [*6] |-> !power_good_out_oe_n)
		else $error("power good released in undervoltage");
	a_ov_clamp: assert property ((ov_ref_trip && por_ok &&
		(ov_fixed_trip || !fixed_overvoltage_limit_enable)) [*6] |-> low_side_drive_force == 3'h7)
		else $error("low sides not forced in overvoltage");
	a_ov_pg_low: assert property (low_side_drive_force != 3'h0 |-> !power_good_out_oe_n)
		else $error("power good released during clamp");
	a_oc_gates_off: assert property (overcurrent [*6] |-> high_side_drive_enable == 3'h0)
		else $error("high sides on in overcurrent");
	a_open_sense_off: assert property (open_sense [*6] |-> high_side_drive_enable == 3'h0 && !power_good_out_oe_n)
		else $error("converter running with open sense");
	a_pg_after_ss: assert property (power_good_out_oe_n |-> !fixed_overvoltage_limit_enable)
		else $error("power good released during soft start");
endmodule : fault_supervisor_checker

bind fault_supervisor_power_good fault_supervisor_checker u_fault_supervisor_checker (.hclk, .hresetn, .hreadyout,
	.hresp, .threshold_enable_in, .por_ok, .uv_below_82, .ov_ref_trip, .ov_fixed_trip, .open_sense, .overcurrent,
	.power_good_out_oe_n, .low_side_drive_force, .high_side_drive_enable, .fixed_overvoltage_limit_enable);
`default_nettype wire

/* dv/power_stage_model.sv */
// Purpose: Power stage oscillator and power-good pull-up
// Assumes: Switching clock runs free, 8 hclk a cycle
// Notes: Line reads high only when the drain is released
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
	input wire logic hclk,
	input wire logic power_good_out_o,
	input wire logic power_good_out_oe_n,
	output logic phase_tick,
	output logic pg_line
);
	logic [2:0] cnt = 3'h0;
	always @(posedge hclk) begin
		cnt <= cnt + 3'h1;
	end
	assign phase_tick = cnt[2];
	// Pull-up on the open-drain line
	assign pg_line = power_good_out_oe_n ? 1'b1 : power_good_out_o;
endmodule : power_stage_model
`default_nettype wire

/* dv/fault_supervisor_power_good_tb.sv */
// Purpose: Self-checking bench for the fault supervisor
// Assumes: Hiccup wait shortened to 8 ticks
// Notes: Checks read values settled before each edge
`include "fault_supervisor_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module fault_supervisor_power_good_tb;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, threshold_enable_in = 1'b0, por_ok = 1'b1;
	logic uv_below_82 = 1'b0, uv_above_85 = 1'b1, ov_ref_trip = 1'b0, ov_ref_clear = 1'b1, ov_fixed_trip = 1'b0;
	logic ov_fixed_clear = 1'b1, open_sense = 1'b0, overcurrent = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, phase_tick, pg_line, power_good_out_o, power_good_out_oe_n;
	logic [2:0] low_side_drive_force, low_side_drive_enable, high_side_drive_enable;
	logic [7:0] ref_code;
	logic fixed_overvoltage_limit_enable, fixed_overvoltage_limit_high, overvoltage_shutdown_level;
	int n_errors = 0;
	int checks_done = 0;
	always #2.5 hclk = ~hclk;
	fault_supervisor_power_good #(.OC_WAIT_TICKS(13'h0008)) u_fault_supervisor_power_good (.hclk, .hresetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.threshold_enable_in, .por_ok, .phase_tick, .uv_below_82, .uv_above_85, .ov_ref_trip, .ov_ref_clear,
		.ov_fixed_trip, .ov_fixed_clear, .open_sense, .overcurrent, .power_good_out_o, .power_good_out_oe_n,
		.low_side_drive_force, .low_side_drive_enable, .high_side_drive_enable, .ref_code,
		.fixed_overvoltage_limit_enable, .fixed_overvoltage_limit_high, .overvoltage_shutdown_level);
	power_stage_model u_power_stage_model (.hclk, .power_good_out_o, .power_good_out_oe_n, .phase_tick, .pg_line);
	// ----
	// Shared tasks
	// ----
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : bus
	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	task state_is(input logic [4:0] s);
		bus(1'b0, `STATUS_ADDR, 32'h0);
		chk("state", {27'h0, s}, {27'h0, rd[4:0]});
	endtask : state_is
	task wait_pg;
		int i;
		for (i = 0; i < 4000 && pg_line !== 1'b1; i++) @(posedge hclk);
		chk("pg line", 32'h1, {31'h0, pg_line});
	endtask : wait_pg
	task wrap_up;
		if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// ----
	// Scenarios
	// ----
	task t_start;
		int i;
		chk("pg in reset", 32'h0, {31'h0, pg_line});
		hresetn <= 1'b1;
		threshold_enable_in <= 1'b1;
		for (i = 0; i < 3; i++) begin
			bus(1'b1, `CTRL_ADDR, {16'h0, 8'h02, 6'h05, 2'(2 - i)});
			cyc(4);
			chk("fixed high", {31'h0, i == 1}, {31'h0, fixed_overvoltage_limit_high});
		end
		chk("fixed en", 32'h1, {31'h0, fixed_overvoltage_limit_enable});
		bus(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, rd);
		cyc(50);
		state_is(5'h02);
		for (i = 0; i < 2000 && ref_code !== 8'h01; i++) @(posedge hclk);
		for (i = 0; i < 2000 && ref_code !== 8'h02; i++) @(posedge hclk);
		chk("step span", 32'h1, {31'h0, i >= 124 && i <= 132});
		wait_pg();
		chk("fixed en run", 32'h0, {31'h0, fixed_overvoltage_limit_enable});
		chk("high sides", 32'h7, {29'h0, high_side_drive_enable});
		chk("low enables", 32'h7, {29'h0, low_side_drive_enable});
		chk("ref target", 32'h2, {24'h0, ref_code});
	endtask : t_start
	task t_ov;
		int i;
		for (i = 0; i < 2; i++) begin
			ov_ref_trip <= 1'b1;
			ov_ref_clear <= 1'b0;
			cyc(8);
			chk("clamp", 32'h7, {29'h0, low_side_drive_force});
			chk("pg ov", 32'h0, {31'h0, pg_line});
			ov_ref_trip <= 1'b0;
			cyc(8);
			chk("clamp hyst", 32'h7, {29'h0, low_side_drive_force});
			ov_ref_clear <= 1'b1;
			cyc(8);
			chk("unclamp", 32'h0, {29'h0, low_side_drive_force});
			chk("pg back", 32'h1, {31'h0, pg_line});
		end
		state_is(5'h08);
		ov_fixed_trip <= 1'b1;
		cyc(8);
		chk("fixed ignored", 32'h0, {29'h0, low_side_drive_force});
		ov_fixed_trip <= 1'b0;
	endtask : t_ov
	task t_uv;
		uv_below_82 <= 1'b1;
		uv_above_85 <= 1'b0;
		cyc(8);
		chk("pg uv", 32'h0, {31'h0, pg_line});
		chk("uv no action", 32'h7, {29'h0, high_side_drive_enable});
		uv_below_82 <= 1'b0;
		cyc(8);
		chk("pg uv band", 32'h0, {31'h0, pg_line});
		uv_above_85 <= 1'b1;
		cyc(8);
		chk("pg uv end", 32'h1, {31'h0, pg_line});
	endtask : t_uv
	task t_oc;
		overcurrent <= 1'b1;
		cyc(8);
		chk("oc gates", 32'h0, {26'h0, low_side_drive_enable, high_side_drive_enable});
		overcurrent <= 1'b0;
		cyc(30);
		state_is(5'h10);
		cyc(60);
		state_is(5'h02);
		wait_pg();
	endtask : t_oc
	task t_open;
		open_sense <= 1'b1;
		cyc(8);
		state_is(5'h01);
		open_sense <= 1'b0;
		cyc(8);
		ov_ref_trip <= 1'b1;
		ov_ref_clear <= 1'b0;
		cyc(8);
		chk("ref alone in ss", 32'h0, {29'h0, low_side_drive_force});
		ov_fixed_trip <= 1'b1;
		ov_fixed_clear <= 1'b0;
		cyc(8);
		chk("fixed clamp", 32'h7, {29'h0, low_side_drive_force});
		ov_fixed_trip <= 1'b0;
		ov_fixed_clear <= 1'b1;
		cyc(8);
		chk("fixed release", 32'h0, {29'h0, low_side_drive_force});
		ov_ref_trip <= 1'b0;
		ov_ref_clear <= 1'b1;
		state_is(5'h02);
		chk("ov cause", 32'h1, {31'h0, rd[7]});
		wait_pg();
	endtask : t_open
	task t_noload;
		int i;
		for (i = 0; i < 2; i++) begin
			bus(1'b1, `CTRL_ADDR, {16'h0, 8'h02, 5'h1F, 1'(i), 2'h0});
			cyc(4);
			chk("noload wait", 32'h0, {31'h0, overvoltage_shutdown_level});
			cyc(40);
			chk("noload", 32'h1, {31'h0, overvoltage_shutdown_level});
			chk("noload off", 32'h0, {30'h0, pg_line, high_side_drive_enable[0]});
			bus(1'b1, `CTRL_ADDR, 32'h0000_0215);
			wait_pg();
		end
	endtask : t_noload
	task t_disable;
		int i;
		for (i = 0; i < 2; i++) begin
			if (i == 0) threshold_enable_in <= 1'b0;
			else por_ok <= 1'b0;
			cyc(8);
			state_is(5'h01);
			threshold_enable_in <= 1'b1;
			por_ok <= 1'b1;
			wait_pg();
		end
	endtask : t_disable
	initial begin
		cyc(16);
		t_start();
		t_ov();
		t_uv();
		t_oc();
		t_open();
		t_noload();
		t_disable();
		wrap_up();
	end
	initial begin
		#150000;
		n_errors++;
		wrap_up();
	end
endmodule : fault_supervisor_power_good_tb
`default_nettype wire
